// [wad_detector.sv]
// Contract
// - Serial link runs at 115200 bits per second.
// - Characters are eight data, no parity, one stop.
// - Gripper bus address must lie in one..nine.
// - Whole pattern completes within five seconds.
// - Pattern ignored until gripper detection confirmed.
// - Valid pattern while active reactivates coupling.
// - Activation starts the gripper activation routine.
// - After power cycle or new device, stay inactive.
// - Steps: both low, in0 up/down, in1 up/down.
module wad_detector
  import wad_pkg::*;
#(
  parameter int unsigned STEP_MIN_CYC_P = STEP_MIN_CYC,
  parameter int unsigned SEQ_MAX_CYC_P  = SEQ_MAX_CYC,
  parameter int unsigned FIFO_DEPTH_P   = FIFO_DEPTH
) (
  input  wire logic       CORE_CLK,
  input  wire logic       SRST,
  input  wire logic       DIN0,
  input  wire logic       DIN1,
  input  wire logic       GRIP_DETECT,
  input  wire logic [3:0] GRIP_ADDR,
  output logic            LED_BLUE,
  output logic            COUPLING_ACTIVE,
  output logic            ACT_PULSE,
  output logic            ADDR_FAULT,
  output logic            UART_TX,
  output logic            TX_BUSY
);

  initial begin
    if (STEP_MIN_CYC_P < 1 || SEQ_MAX_CYC_P <= STEP_MIN_CYC_P || SEQ_MAX_CYC_P >= (1 << TMR_W)) begin
      $error("Pattern timing parameters out of range");
    end
  end

  localparam logic [TMR_W-1:0] MIN_C  = TMR_W'(STEP_MIN_CYC_P);
  localparam logic [TMR_W-1:0] MAX_C  = TMR_W'(SEQ_MAX_CYC_P);
  localparam logic [DIV_W-1:0] DIV_TOP = DIV_W'(BIT_CYC - 1);
  localparam logic [BITCNT_W-1:0] LAST_BIT = BITCNT_W'(DATA_BITS + STOP_BITS);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(FRAME_LEN - 1);

  // ************************************************************
  // Pattern detector
  // ************************************************************
  wad_state_e       st_r, st_nxt;
  logic             d0_r, d1_r, det_r;
  logic [TMR_W-1:0] gap_r, tot_r;
  logic             active_r, act_pulse_r, led_r;

  wire rise0 = DIN0 && !d0_r;
  wire fall0 = !DIN0 && d0_r;
  wire rise1 = DIN1 && !d1_r;
  wire fall1 = !DIN1 && d1_r;
  wire any_edge = rise0 || fall0 || rise1 || fall1;
  wire exp_edge = (st_r == ST_LOW && rise0) || (st_r == ST_D0H && fall0) ||
                  (st_r == ST_D0L && rise1) || (st_r == ST_D1H && fall1);
  wire two_line = (rise0 || fall0) && (rise1 || fall1);
  wire stray    = any_edge && (!exp_edge || two_line);
  // The count restarts at zero on the step change, so it trails the hold by one.
  wire gap_ok   = gap_r >= MIN_C - 1'b1;
  wire late     = tot_r >= MAX_C;
  wire step_ok  = exp_edge && gap_ok && !late && !stray;
  wire addr_ok  = GRIP_ADDR >= ADDR_MIN && GRIP_ADDR <= ADDR_MAX;
  wire done     = GRIP_DETECT && st_r == ST_D1H && step_ok;
  wire act_go   = done && addr_ok;

  always_comb begin
    st_nxt = st_r;
    if (!GRIP_DETECT) begin
      st_nxt = ST_WAIT;
    end else begin
      case (st_r)
        ST_WAIT: begin
          if (!DIN0 && !DIN1) begin
            st_nxt = ST_LOW;
          end
        end
        ST_LOW, ST_D0H, ST_D0L, ST_D1H: begin
          if (late || stray || (exp_edge && !gap_ok)) begin
            st_nxt = ST_WAIT;
          end else if (exp_edge) begin
            case (st_r)
              ST_LOW:  st_nxt = ST_D0H;
              ST_D0H:  st_nxt = ST_D0L;
              ST_D0L:  st_nxt = ST_D1H;
              default: st_nxt = ST_WAIT;
            endcase
          end
        end
        default: st_nxt = ST_WAIT;
      endcase
    end
  end

  wire [TMR_W-1:0] gap_nxt = (st_nxt != st_r || st_r == ST_WAIT) ? '0 :
                             (gap_r == MAX_C) ? gap_r : gap_r + 1'b1;
  wire [TMR_W-1:0] tot_nxt = (st_nxt == ST_WAIT) ? '0 :
                             (tot_r == MAX_C) ? tot_r : tot_r + 1'b1;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      st_r  <= ST_WAIT;
      gap_r <= '0;
      tot_r <= '0;
      d0_r  <= 1'b0;
      d1_r  <= 1'b0;
      det_r <= 1'b0;
      led_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      gap_r <= gap_nxt;
      tot_r <= tot_nxt;
      d0_r  <= DIN0;
      d1_r  <= DIN1;
      det_r <= GRIP_DETECT;
      led_r <= GRIP_DETECT;
    end
  end

  wire active_nxt = act_go ? 1'b1 : (det_r && !GRIP_DETECT) ? 1'b0 : active_r;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      active_r    <= ACTIVE_RST;
      act_pulse_r <= 1'b0;
    end else begin
      active_r    <= active_nxt;
      act_pulse_r <= act_go;
    end
  end

  // ************************************************************
  // Gripper activation command
  // ************************************************************
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] v;
    v = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      v = v[0] ? ((v >> 1) ^ CRC_POLY) : (v >> 1);
    end
    return v;
  endfunction

  logic             pend_r, busy_r;
  logic [IDX_W-1:0] idx_r;
  logic [15:0]      crc_r;
  logic [3:0]       addr_r;
  logic [7:0]       cmd_byte;
  logic             f_in_ready, f_out_valid, f_out_ready;
  logic [7:0]       f_out_data;

  always_comb begin
    case (idx_r)
      4'h0:    cmd_byte = {4'h0, addr_r};
      4'h1:    cmd_byte = FN_WRITE;
      4'h2:    cmd_byte = REG_HI;
      4'h3:    cmd_byte = REG_LO;
      4'h4:    cmd_byte = CNT_HI;
      4'h5:    cmd_byte = CNT_LO;
      4'h6:    cmd_byte = NBYTES;
      4'h7:    cmd_byte = ACT_HI;
      4'h8:    cmd_byte = ACT_LO;
      4'h9:    cmd_byte = crc_r[7:0];
      default: cmd_byte = crc_r[15:8];
    endcase
  end

  wire push  = busy_r && f_in_ready;
  wire start = pend_r && !busy_r;
  wire crc_hold = idx_r >= IDX_W'(FRAME_LEN - 2);

  // A new activation during a frame is held and sent whole afterwards, never spliced in.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      pend_r <= 1'b0;
      busy_r <= 1'b0;
      idx_r  <= '0;
      crc_r  <= CRC_INIT;
      addr_r <= 4'h0;
    end else begin
      pend_r <= act_go || (pend_r && !start);
      // Keep the address that passed the range check; later pin changes cannot reach the frame.
      addr_r <= act_go ? GRIP_ADDR : addr_r;
      if (start) begin
        busy_r <= 1'b1;
        idx_r  <= '0;
        crc_r  <= CRC_INIT;
      end else if (push) begin
        idx_r  <= idx_r + 1'b1;
        crc_r  <= crc_hold ? crc_r : crc_byte(crc_r, cmd_byte);
        busy_r <= idx_r != LAST_IDX;
      end
    end
  end

  wad_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH_P)) i_wad_fifo (
    .CORE_CLK  (CORE_CLK),
    .SRST      (SRST),
    .in_valid  (busy_r),
    .in_ready  (f_in_ready),
    .in_data   (cmd_byte),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // ************************************************************
  // Serial transmitter
  // ************************************************************
  logic                tx_busy_r;
  logic [9:0]          shift_r;
  logic [DIV_W-1:0]    div_r;
  logic [BITCNT_W-1:0] bit_r;

  assign f_out_ready = !tx_busy_r;
  wire take    = f_out_valid && !tx_busy_r;
  wire bit_end = tx_busy_r && div_r == DIV_TOP;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      tx_busy_r <= 1'b0;
      shift_r   <= 10'h3FF;
      div_r     <= '0;
      bit_r     <= '0;
    end else if (take) begin
      tx_busy_r <= 1'b1;
      shift_r   <= {1'b1, f_out_data, 1'b0};
      div_r     <= '0;
      bit_r     <= '0;
    end else if (bit_end) begin
      shift_r   <= {1'b1, shift_r[9:1]};
      div_r     <= '0;
      bit_r     <= bit_r + 1'b1;
      tx_busy_r <= bit_r != LAST_BIT;
    end else if (tx_busy_r) begin
      div_r <= div_r + 1'b1;
    end
  end

  assign UART_TX         = shift_r[0];
  assign TX_BUSY         = tx_busy_r || busy_r || pend_r || f_out_valid;
  assign LED_BLUE        = led_r;
  assign COUPLING_ACTIVE = active_r;
  assign ACT_PULSE       = act_pulse_r;
  assign ADDR_FAULT      = !addr_ok;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  baud_period_a: assert property (tx_busy_r && !bit_end |=> div_r == $past(div_r) + 1'b1 || take)
    else $error("Bit timer stalled");
  stop_bit_a: assert property (tx_busy_r && bit_r == LAST_BIT |-> UART_TX)
    else $error("Stop bit not high");
  start_bit_a: assert property (take |=> !UART_TX [*8])
    else $error("Start bit not low");
  addr_range_a: assert property (start |=> addr_r >= ADDR_MIN && addr_r <= ADDR_MAX)
    else $error("Activation with bad address");
  early_step_a: assert property (exp_edge && !gap_ok |=> st_r == ST_WAIT)
    else $error("Early step accepted");
  seq_deadline_a: assert property (late && st_r != ST_WAIT |=> st_r == ST_WAIT)
    else $error("Late pattern accepted");
  detect_gate_a: assert property (!GRIP_DETECT |=> st_r == ST_WAIT && !ACT_PULSE)
    else $error("Pattern used without detection");
  reactivate_a: assert property (done && addr_ok && active_r |=> ACT_PULSE && active_r)
    else $error("Reactivation missed");
  gripper_act_a: assert property (act_go && !busy_r && !pend_r |-> ##[1:3] (busy_r && idx_r == 0))
    else $error("Gripper command not started");
  new_device_a: assert property ($fell(GRIP_DETECT) |=> !COUPLING_ACTIVE)
    else $error("Stayed active after device change");
  step_order_a: assert property (st_r == ST_D1H && $past(st_r) != ST_D1H |-> $past(st_r) == ST_D0L && DIN1)
    else $error("Step out of order");
  stray_edge_a: assert property (stray && st_r != ST_WAIT |=> st_r == ST_WAIT)
    else $error("Stray edge kept progress");

  act_first_c: cover property (act_go && !active_r);
  act_again_c: cover property (act_go && active_r);
  late_abort_c: cover property (late && st_r == ST_D0L);
  early_abort_c: cover property (exp_edge && !gap_ok && st_r == ST_D0H);

endmodule

// [wad_pkg.sv]
package wad_pkg;

  // ************************************************************
  // Time base and link framing
  // ************************************************************
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned BAUD_BPS     = 115200;
  localparam int unsigned BIT_CYC      = (CLK_HZ + BAUD_BPS / 2) / BAUD_BPS;
  localparam int unsigned DATA_BITS    = 8;
  localparam int unsigned STOP_BITS    = 1;
  localparam int unsigned DIV_W        = 12;
  localparam int unsigned BITCNT_W     = 4;

  // ************************************************************
  // Activation pattern timing
  // ************************************************************
  localparam int unsigned STEP_MIN_MS  = 10;
  localparam int unsigned SEQ_MAX_MS   = 5000;
  localparam int unsigned STEP_MIN_CYC = STEP_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned SEQ_MAX_CYC  = SEQ_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W        = 31;

  // ************************************************************
  // Gripper address and activation command
  // ************************************************************
  localparam logic [3:0]  ADDR_MIN     = 4'h1;
  localparam logic [3:0]  ADDR_MAX     = 4'h9;
  localparam logic [7:0]  FN_WRITE     = 8'h10;
  localparam logic [7:0]  REG_HI       = 8'h03;
  localparam logic [7:0]  REG_LO       = 8'hE8;
  localparam logic [7:0]  CNT_HI       = 8'h00;
  localparam logic [7:0]  CNT_LO       = 8'h01;
  localparam logic [7:0]  NBYTES       = 8'h02;
  localparam logic [7:0]  ACT_HI       = 8'h01;
  localparam logic [7:0]  ACT_LO       = 8'h00;
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] CRC_POLY     = 16'hA001;
  localparam int unsigned FRAME_LEN    = 11;
  localparam int unsigned IDX_W        = 4;
  localparam int unsigned FIFO_DEPTH   = 32;
  localparam logic        ACTIVE_RST   = 1'b0;

  typedef enum logic [2:0] {ST_WAIT, ST_LOW, ST_D0H, ST_D0L, ST_D1H} wad_state_e;

endpackage

// [wad_fifo.sv]
module wad_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             CORE_CLK,
  input  wire logic             SRST,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("FIFO depth must be a power of two of at least two");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  wire              full  = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire              empty = (wr_r == rd_r);
  wire              push  = in_valid && !full;
  wire              pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_r[AW-1:0]];

  always_ff @(posedge CORE_CLK) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_r + (AW+1)'(push);
      rd_r <= rd_r + (AW+1)'(pop);
    end
  end

  fifo_full_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    full && !pop |=> full) else $error("FIFO lost a word while full");

endmodule

// [wad_ctrl_model.sv]
module wad_ctrl_model (
  input  wire logic clk,
  output logic      din0,
  output logic      din1
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    din0 = 1'b0;
    din1 = 1'b0;
  end

  // ************************************************************
  // Controller output steps
  // ************************************************************
  // step hold time
  task automatic put(input logic d0, input logic d1, input int hold);
    @(posedge clk);
    din0 <= d0;
    din1 <= d1;
    repeat (hold - 1) @(posedge clk);
  endtask

  // ordered five steps
  // Both lines go high first so the detector aborts and restarts cleanly at step one.
  task automatic pattern(input int hold);
    put(1'b1, 1'b1, 2);
    put(1'b0, 1'b0, hold);
    put(1'b1, 1'b0, hold);
    put(1'b0, 1'b0, hold);
    put(1'b0, 1'b1, hold);
    put(1'b0, 1'b0, hold);
  endtask
endmodule

// [test_wad_detector.sv]
module test_wad_detector
  import wad_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned MIN_P = 20;
  localparam int unsigned MAX_P = 400;

  logic       core_clk;
  logic       srst;
  logic       grip_detect;
  logic [3:0] grip_addr;
  logic       din0;
  logic       din1;
  logic       led_blue;
  logic       coupling_active;
  logic       act_pulse;
  logic       addr_fault;
  logic       uart_tx;
  logic       tx_busy;
  logic [7:0] rx_b;
  int         bad_count;
  int         cmp_count;
  int         pulse_cnt;
  int         base;

  wad_detector #(
    .STEP_MIN_CYC_P (MIN_P),
    .SEQ_MAX_CYC_P  (MAX_P)
  ) i_wad_detector (
    .CORE_CLK        (core_clk),
    .SRST            (srst),
    .DIN0            (din0),
    .DIN1            (din1),
    .GRIP_DETECT     (grip_detect),
    .GRIP_ADDR       (grip_addr),
    .LED_BLUE        (led_blue),
    .COUPLING_ACTIVE (coupling_active),
    .ACT_PULSE       (act_pulse),
    .ADDR_FAULT      (addr_fault),
    .UART_TX         (uart_tx),
    .TX_BUSY         (tx_busy)
  );

  wad_ctrl_model i_wad_ctrl_model (
    .clk  (core_clk),
    .din0 (din0),
    .din1 (din1)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (act_pulse === 1'b1) begin
      pulse_cnt <= pulse_cnt + 1;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic expect_act(input int n, input logic act);
    tick(2);
    chk("pulse_count", 8'(n), 8'(pulse_cnt - base));
    chk("coupling_active", {7'h0, act}, {7'h0, coupling_active});
  endtask

  // Samples mid-bit, so a wrong bit period drifts off the data within a byte.
  task automatic rx_byte(output logic [7:0] b);
    int n;
    n = 0;
    while (uart_tx !== 1'b0 && n < 3 * BIT_CYC) begin
      tick(1);
      n++;
    end
    tick(BIT_CYC / 2);
    chk("start_bit", 8'h00, {7'h0, uart_tx});
    for (int i = 0; i < 8; i++) begin
      tick(BIT_CYC);
      b[i] = uart_tx;
    end
    tick(BIT_CYC);
    chk("stop_bit", 8'h01, {7'h0, uart_tx});
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_gated();
    base = pulse_cnt;
    i_wad_ctrl_model.pattern(30);
    expect_act(0, 1'b0);
    @(posedge core_clk);
    grip_detect <= 1'b1;
    tick(2);
    chk("led_blue", 8'h01, {7'h0, led_blue});
    $display("gated test done");
  endtask

  task automatic t_bad_timing();
    base = pulse_cnt;
    i_wad_ctrl_model.pattern(MIN_P - 1);
    expect_act(0, 1'b0);
    i_wad_ctrl_model.pattern(120);
    expect_act(0, 1'b0);
    i_wad_ctrl_model.put(1'b1, 1'b1, 2);
    i_wad_ctrl_model.put(1'b0, 1'b0, 30);
    i_wad_ctrl_model.put(1'b0, 1'b1, 30);
    i_wad_ctrl_model.put(1'b0, 1'b0, 30);
    i_wad_ctrl_model.put(1'b1, 1'b0, 30);
    i_wad_ctrl_model.put(1'b0, 1'b0, 30);
    expect_act(0, 1'b0);
    // Both lines rise together while the second line's rise is expected.
    i_wad_ctrl_model.put(1'b1, 1'b1, 30);
    i_wad_ctrl_model.put(1'b0, 1'b0, 30);
    expect_act(0, 1'b0);
    $display("timing test done");
  endtask

  task automatic t_addr();
    for (int a = 0; a < 16; a++) begin
      @(posedge core_clk);
      grip_addr <= 4'(a);
      tick(1);
      chk("addr_fault", {7'h0, a < 1 || a > 9}, {7'h0, addr_fault});
    end
    @(posedge core_clk);
    grip_addr <= 4'h0;
    base = pulse_cnt;
    i_wad_ctrl_model.pattern(30);
    expect_act(0, 1'b0);
    @(posedge core_clk);
    grip_addr <= 4'h9;
    $display("address test done");
  endtask

  task automatic t_activate();
    base = pulse_cnt;
    fork
      i_wad_ctrl_model.pattern(30);
      rx_byte(rx_b);
    join
    chk("frame_addr", 8'h09, rx_b);
    expect_act(1, 1'b1);
    chk("tx_busy", 8'h01, {7'h0, tx_busy});
    rx_byte(rx_b);
    chk("frame_func", FN_WRITE, rx_b);
    base = pulse_cnt;
    i_wad_ctrl_model.pattern(30);
    expect_act(1, 1'b1);
    $display("activation test done");
  endtask

  task automatic t_detach();
    @(posedge core_clk);
    grip_detect <= 1'b0;
    tick(3);
    chk("coupling_active", 8'h00, {7'h0, coupling_active});
    chk("led_blue", 8'h00, {7'h0, led_blue});
    @(posedge core_clk);
    grip_detect <= 1'b1;
    tick(5);
    chk("coupling_active", 8'h00, {7'h0, coupling_active});
    $display("detach test done");
  endtask

  // Steps held exactly the minimum must be taken; a mid-run reset then clears the coupling and the serial transmission.
  task automatic t_power();
    base = pulse_cnt;
    i_wad_ctrl_model.pattern(MIN_P);
    expect_act(1, 1'b1);
    @(posedge core_clk);
    srst <= 1'b1;
    tick(3);
    @(posedge core_clk);
    srst <= 1'b0;
    tick(1);
    chk("coupling_active", 8'h00, {7'h0, coupling_active});
    chk("tx_busy", 8'h00, {7'h0, tx_busy});
    chk("uart_tx", 8'h01, {7'h0, uart_tx});
    $display("power cycle test done");
  endtask

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    srst = 1'b1;
    grip_detect = 1'b0;
    grip_addr = 4'h9;
    bad_count = 0;
    cmp_count = 0;
    pulse_cnt = 0;
    base = 0;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    tick(1);
    chk("led_blue", 8'h00, {7'h0, led_blue});
    chk("coupling_active", 8'h00, {7'h0, coupling_active});
    chk("act_pulse", 8'h00, {7'h0, act_pulse});
    chk("uart_tx", 8'h01, {7'h0, uart_tx});
    chk("tx_busy", 8'h00, {7'h0, tx_busy});
    $display("reset test done");
    t_gated();
    t_bad_timing();
    t_addr();
    t_activate();
    t_detach();
    t_power();
    end_sim();
  end

  // The run needs under 50000 cycles; the margin covers slow serial framing.
  initial begin
    repeat (80000) @(posedge core_clk);
    bad_count++;
    end_sim();
  end
endmodule
